// ==== rtl/indicator_pattern_gen.sv ====
// pulse pattern generator for one indicator output
`timescale 1ns/100ps
`default_nettype none
module indicator_pattern_gen
(
	input  wire logic              ref_clk,
	input  wire logic              nrst,
	input  wire logic              tick,
	input  wire led_pkg::pattern_t pat,
	output logic                   lamp,
	output logic                   done
);

	typedef enum logic [2:0] {
		PH_OFF       = 3'b000,
		PH_ON        = 3'b001,
		PH_PULSE_ON  = 3'b010,
		PH_PULSE_OFF = 3'b011,
		PH_DONE      = 3'b100
	} phase_t;

	typedef struct packed {
		phase_t            phase;
		logic [6:0]        cnt;
		logic [2:0]        pulses;
		led_pkg::pattern_t prev;
		logic              lamp;
		logic              done;
	} gen_state_t;

	gen_state_t st_reg;
	gen_state_t st_next;
	logic [6:0] on_len;
	logic [6:0] off_len;

	assign on_len  = led_pkg::on_ticks(st_reg.prev.on_sel);
	assign off_len = 7'(on_len * led_pkg::off_ratio(st_reg.prev.ratio_sel));

	always_comb
	begin
		st_next = st_reg;
		if (pat != st_reg.prev)
		begin
			// any change of pattern restarts it from its first phase: off, constant on or the first pulse on phase
			st_next.prev   = pat;
			st_next.cnt    = 7'h00;
			st_next.pulses = 3'h0;
			case (pat.mode)
				led_pkg::MODE_OFF:   st_next.phase = PH_OFF;
				led_pkg::MODE_CONST: st_next.phase = PH_ON;
				default:             st_next.phase = PH_PULSE_ON;
			endcase
		end
		else
		begin
			case (st_reg.phase)
				PH_PULSE_ON:
				begin
					if (tick)
					begin
						if (st_reg.cnt + 7'h01 >= on_len)
						begin
							st_next.cnt    = 7'h00;
							st_next.pulses = st_reg.pulses + 3'h1;
							st_next.phase  = PH_PULSE_OFF;
						end
						else
							st_next.cnt = st_reg.cnt + 7'h01;
					end
				end
				PH_PULSE_OFF:
				begin
					if (tick)
					begin
						if (st_reg.cnt + 7'h01 >= off_len)
						begin
							st_next.cnt = 7'h00;
							if (st_reg.prev.mode == led_pkg::MODE_SEQ
								&& st_reg.pulses == st_reg.prev.count)
								st_next.phase = PH_DONE;
							else
								st_next.phase = PH_PULSE_ON;
						end
						else
							st_next.cnt = st_reg.cnt + 7'h01;
					end
				end
				PH_OFF, PH_ON, PH_DONE:
					st_next.cnt = 7'h00;
				default:
					st_next.phase = PH_OFF;
			endcase
		end
		st_next.lamp = (st_next.phase == PH_ON) || (st_next.phase == PH_PULSE_ON);
		st_next.done = (st_next.phase == PH_DONE);
	end

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign lamp = st_reg.lamp;
	assign done = st_reg.done;

endmodule
`default_nettype wire

// ==== rtl/led_pkg.sv ====
// shared types, register map and timing constants of the status indicator driver
package led_pkg;

	// ------------------------------------------------------------
	// register map: word index, byte address is four times it
	// ------------------------------------------------------------
	localparam logic [29:0] IDX_IND_ONE  = 30'h0000404c;
	localparam logic [29:0] IDX_IND_TWO  = 30'h0000404d;
	localparam logic [29:0] IDX_THRESH   = 30'h0000404e;
	localparam logic [29:0] IDX_STATUS   = 30'h0000404f;
	localparam int          BUS_W        = 32;
	localparam int          CTRL_W       = 16;
	localparam int          THR_W        = 12;
	localparam logic [15:0] CTRL_RESET   = 16'hc026;
	localparam logic [11:0] THR_RESET    = 12'h800;

	// status register bit positions
	localparam int ST_AP_DONE   = 0;
	localparam int ST_AP_ERR    = 1;
	localparam int ST_LOW       = 2;
	localparam int ST_FAIL      = 3;
	localparam int ST_LAMP_LSB  = 4;
	localparam int ST_PWR_LSB   = 6;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam real         TICK_TIME_MS  = 62.5;
	localparam real         CLK_PERIOD_NS = 100.0;
	localparam int          TICK_CYCLES   = int'(TICK_TIME_MS * 1.0e6 / CLK_PERIOD_NS);
	localparam logic [6:0]  TICKS_1S      = 7'(int'(1000.0 / TICK_TIME_MS));
	localparam logic [6:0]  TICKS_250MS   = 7'(int'(250.0 / TICK_TIME_MS));
	localparam logic [6:0]  TICKS_125MS   = 7'(int'(125.0 / TICK_TIME_MS));
	localparam logic [6:0]  TICKS_62MS    = 7'(int'(62.5 / TICK_TIME_MS));
	localparam logic [2:0]  RATIO_1_1     = 3'h1;
	localparam logic [2:0]  RATIO_1_2     = 3'h2;
	localparam logic [2:0]  RATIO_1_3     = 3'h3;
	localparam logic [2:0]  RATIO_1_7     = 3'h7;
	localparam logic [2:0]  SEQ_1         = 3'h1;
	localparam logic [2:0]  SEQ_2         = 3'h2;
	localparam logic [2:0]  SEQ_4         = 3'h4;
	localparam logic [2:0]  SEQ_7         = 3'h7;

	// on time and ratio codes of the power-state patterns
	localparam logic [1:0]  SEL_ON_1S     = 2'h0;
	localparam logic [1:0]  SEL_ON_250MS  = 2'h1;
	localparam logic [1:0]  SEL_RATIO_1_1 = 2'h0;
	localparam logic [1:0]  SEL_RATIO_1_3 = 2'h2;
	localparam logic [1:0]  SEL_RATIO_1_7 = 2'h3;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SRC_OFF    = 2'b00,
		SRC_POWER  = 2'b01,
		SRC_RSVD   = 2'b10,
		SRC_MANUAL = 2'b11
	} src_t;

	typedef enum logic [1:0] {
		MODE_OFF   = 2'b00,
		MODE_CONST = 2'b01,
		MODE_CONT  = 2'b10,
		MODE_SEQ   = 2'b11
	} mode_t;

	typedef enum logic [1:0] {
		PWR_OFF    = 2'b00,
		PWR_ACTIVE = 2'b01,
		PWR_SLEEP  = 2'b10,
		PWR_TRANS  = 2'b11
	} pwr_t;

	typedef struct packed {
		logic [1:0] indicator_source_field;
		logic [3:0] unused_hi;
		logic [1:0] manual_pattern_select;
		logic [1:0] unused_mid;
		logic [1:0] pulse_sequence_count;
		logic [1:0] pulse_on_time;
		logic [1:0] pulse_on_off_ratio;
	} ind_ctrl_t;

	typedef struct packed {
		mode_t      mode;
		logic [1:0] on_sel;
		logic [1:0] ratio_sel;
		logic [2:0] count;
	} pattern_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [31:0] adr;
		logic [31:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_t;

	// ------------------------------------------------------------
	// decoders
	// ------------------------------------------------------------
	function automatic logic [6:0] on_ticks(input logic [1:0] sel);
		case (sel)
			2'h0:    on_ticks = TICKS_1S;
			2'h1:    on_ticks = TICKS_250MS;
			2'h2:    on_ticks = TICKS_125MS;
			default: on_ticks = TICKS_62MS;
		endcase
	endfunction

	function automatic logic [2:0] off_ratio(input logic [1:0] sel);
		case (sel)
			2'h0:    off_ratio = RATIO_1_1;
			2'h1:    off_ratio = RATIO_1_2;
			2'h2:    off_ratio = RATIO_1_3;
			default: off_ratio = RATIO_1_7;
		endcase
	endfunction

	function automatic logic [2:0] seq_count(input logic [1:0] sel);
		case (sel)
			2'h0:    seq_count = SEQ_1;
			2'h1:    seq_count = SEQ_2;
			2'h2:    seq_count = SEQ_4;
			default: seq_count = SEQ_7;
		endcase
	endfunction

endpackage

// ==== rtl/status_led_pattern_driver.sv ====
// two status indicator outputs with power-state, manual and auto-program patterns
//
// Operation
// - two independent digital indicator outputs, each able to drive a lamp directly
// - source settings, except for the failure display, and manual settings act only in the active or sleep power state
// - source field 15:14, reset 11: off, power state, reserved, manual
// - auto-program success drives indicator one constantly on
// - auto-program error drives indicator two constantly on
// - auto-program indication holds until the next device reset
// - auto-program indication overrides whatever the source field holds
// - low supply 250ms on 1:3, active constant on, sleep 250ms on 1:7
// - sequence failure shows four 1s pulses 1:1; off waits for them
// - power conditions rank failure, low supply, active, sleep
// - low supply whenever supply level is below the programmed threshold
// - manual mode field 9:8 selects off, on, continuous or finite pulses
// - on time field 3:2 and ratio field 1:0 shape each pulse
// - length field 5:4 gives 1,2,4,7 pulses, then off until any pattern field or the source changes, or the power state returns to active or sleep
`timescale 1ns/100ps
`default_nettype none
module status_led_pattern_driver
#(
	parameter int TICK_CYCLES = led_pkg::TICK_CYCLES
)
(
	input  wire logic                     ref_clk,
	input  wire logic                     nrst,
	input  wire led_pkg::wb_req_t         wb_req,
	output led_pkg::wb_rsp_t              wb_rsp,
	input  wire led_pkg::pwr_t            pwr_state,
	input  wire logic                     seq_fail,
	input  wire logic [led_pkg::THR_W-1:0] supply_level,
	input  wire logic                     autoprog_done,
	input  wire logic                     autoprog_error,
	output logic                          indicator_one,
	output logic                          indicator_two,
	output logic                          fail_display_busy
);

	localparam int TW = $clog2(TICK_CYCLES + 1);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		led_pkg::ind_ctrl_t [1:0]  ctrl;
		logic [led_pkg::THR_W-1:0] thr;
		logic                      ack;
		logic [led_pkg::BUS_W-1:0] rdata;
		logic [TW-1:0]             tick_cnt;
		logic                      tick;
		logic                      ap_done;
		logic                      ap_err;
		logic                      fail_active;
		logic                      fail_armed;
	} drv_state_t;

	typedef enum logic [2:0] {
		DEC_NONE   = 3'b000,
		DEC_ONE    = 3'b001,
		DEC_TWO    = 3'b010,
		DEC_THRESH = 3'b011,
		DEC_STATUS = 3'b100
	} dec_t;

	drv_state_t        st_reg;
	drv_state_t        st_next;
	led_pkg::pattern_t pat       [2];
	logic [1:0]        lamp;
	logic [1:0]        gen_done;
	logic [1:0]        override;
	logic              low_supply;
	logic              cfg_live;
	led_pkg::pattern_t power_pat;
	led_pkg::pattern_t fail_pat;
	logic              req_new;
	logic              req_write;
	dec_t              dec;

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	function automatic dec_t decode(input logic [31:0] adr);
		if (adr[1:0] != 2'h0)
			decode = DEC_NONE;
		else if (adr[31:2] == led_pkg::IDX_IND_ONE)
			decode = DEC_ONE;
		else if (adr[31:2] == led_pkg::IDX_IND_TWO)
			decode = DEC_TWO;
		else if (adr[31:2] == led_pkg::IDX_THRESH)
			decode = DEC_THRESH;
		else if (adr[31:2] == led_pkg::IDX_STATUS)
			decode = DEC_STATUS;
		else
			decode = DEC_NONE;
	endfunction

	// merge write data into a 16-bit register under the byte enables
	function automatic logic [15:0] merge16(
		input logic [15:0] old,
		input logic [31:0] wdat,
		input logic [3:0]  sel
	);
		merge16 = old;
		if (sel[0])
			merge16[7:0] = wdat[7:0];
		if (sel[1])
			merge16[15:8] = wdat[15:8];
	endfunction

	// an indicator that shows the power state also shows the failure display
	function automatic logic shows_power(input led_pkg::ind_ctrl_t ctrl);
		shows_power = (ctrl.indicator_source_field == led_pkg::SRC_POWER);
	endfunction

	assign dec       = decode(wb_req.adr);
	// a stb held past the ack is a new request, so the master drops it a cycle
	assign req_new   = wb_req.cyc && wb_req.stb && !st_reg.ack;
	// a write lands at the edge where the master sees ack, while the request stands
	assign req_write = wb_req.cyc && wb_req.stb && wb_req.we && st_reg.ack;

	// ------------------------------------------------------------
	// status word
	// ------------------------------------------------------------
	function automatic logic [led_pkg::BUS_W-1:0] status_word(
		input logic       ap_done,
		input logic       ap_err,
		input logic       low,
		input logic       fail,
		input logic [1:0] lamps,
		input logic [1:0] pwr
	);
		status_word                            = '0;
		status_word[led_pkg::ST_AP_DONE]       = ap_done;
		status_word[led_pkg::ST_AP_ERR]        = ap_err;
		status_word[led_pkg::ST_LOW]           = low;
		status_word[led_pkg::ST_FAIL]          = fail;
		status_word[led_pkg::ST_LAMP_LSB +: 2] = lamps;
		status_word[led_pkg::ST_PWR_LSB +: 2]  = pwr;
	endfunction

	// ------------------------------------------------------------
	// power-state pattern
	// ------------------------------------------------------------
	assign low_supply = (supply_level < st_reg.thr);
	assign cfg_live   = (pwr_state == led_pkg::PWR_ACTIVE)
		|| (pwr_state == led_pkg::PWR_SLEEP);
	assign override   = {st_reg.ap_err, st_reg.ap_done};

	always_comb
	begin
		fail_pat.mode      = led_pkg::MODE_SEQ;
		fail_pat.on_sel    = led_pkg::SEL_ON_1S;
		fail_pat.ratio_sel = led_pkg::SEL_RATIO_1_1;
		fail_pat.count     = led_pkg::SEQ_4;
		power_pat          = '0;
		if (low_supply)
		begin
			power_pat.mode      = led_pkg::MODE_CONT;
			power_pat.on_sel    = led_pkg::SEL_ON_250MS;
			power_pat.ratio_sel = led_pkg::SEL_RATIO_1_3;
		end
		else if (pwr_state == led_pkg::PWR_ACTIVE)
			power_pat.mode = led_pkg::MODE_CONST;
		else if (pwr_state == led_pkg::PWR_SLEEP)
		begin
			power_pat.mode      = led_pkg::MODE_CONT;
			power_pat.on_sel    = led_pkg::SEL_ON_250MS;
			power_pat.ratio_sel = led_pkg::SEL_RATIO_1_7;
		end
	end

	// ------------------------------------------------------------
	// per-indicator source selection
	// ------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			pat[i] = '0;
			// auto-program latches beat the failure display, which beats the power state
			if (override[i])
				pat[i].mode = led_pkg::MODE_CONST;
			else if (st_reg.fail_active
				&& shows_power(st_reg.ctrl[i]))
				pat[i] = fail_pat;
			else if (!cfg_live)
				pat[i] = '0;
			else
			begin
				case (st_reg.ctrl[i].indicator_source_field)
					led_pkg::SRC_POWER:
						pat[i] = power_pat;
					led_pkg::SRC_MANUAL:
					begin
						pat[i].mode      = led_pkg::mode_t'(
							st_reg.ctrl[i].manual_pattern_select);
						pat[i].on_sel    = st_reg.ctrl[i].pulse_on_time;
						pat[i].ratio_sel = st_reg.ctrl[i].pulse_on_off_ratio;
						pat[i].count     = led_pkg::seq_count(
							st_reg.ctrl[i].pulse_sequence_count);
					end
					default:
						pat[i] = '0;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// pattern generators, one per output
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : gen_ind
			indicator_pattern_gen u_gen
			(
				.ref_clk (ref_clk),
				.nrst    (nrst),
				.tick    (st_reg.tick),
				.pat     (pat[g]),
				.lamp    (lamp[g]),
				.done    (gen_done[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic fail_clear;
		fail_clear = 1'b1;
		st_next    = st_reg;

		// free-running timebase
		// never restarted by a pattern change, so a first on phase may run a tick short
		if (st_reg.tick_cnt == TW'(TICK_CYCLES - 1))
		begin
			st_next.tick_cnt = '0;
			st_next.tick     = 1'b1;
		end
		else
		begin
			st_next.tick_cnt = st_reg.tick_cnt + TW'(1);
			st_next.tick     = 1'b0;
		end

		// auto-program indications latch until reset
		if (autoprog_done)
			st_next.ap_done = 1'b1;
		if (autoprog_error)
			st_next.ap_err = 1'b1;

		// failure display ends once every showing indicator has finished
		for (int i = 0; i < 2; i++)
		begin
			if (shows_power(st_reg.ctrl[i])
				&& !override[i] && !gen_done[i])
				fail_clear = 1'b0;
		end
		// done flags lag a pattern change by a cycle: arming waits one, so the done
		// left by the previous pattern cannot end the display early
		st_next.fail_armed = st_reg.fail_active;
		if (st_reg.fail_active && st_reg.fail_armed && fail_clear)
		begin
			st_next.fail_active = 1'b0;
			st_next.fail_armed  = 1'b0;
		end
		if (seq_fail)
			st_next.fail_active = 1'b1;

		// bus slave: ack one cycle after the request, drop it the next
		st_next.ack = req_new;
		if (req_new)
		begin
			st_next.rdata = '0;
			case (dec)
				DEC_ONE:
					st_next.rdata[15:0] = st_reg.ctrl[0];
				DEC_TWO:
					st_next.rdata[15:0] = st_reg.ctrl[1];
				DEC_THRESH:
					st_next.rdata[led_pkg::THR_W-1:0] = st_reg.thr;
				DEC_STATUS:
					st_next.rdata = status_word(
						st_reg.ap_done,
						st_reg.ap_err,
						low_supply,
						st_reg.fail_active,
						lamp,
						pwr_state);
				default:
					st_next.rdata = '0;
			endcase
		end

		// writes take effect on the edge that carries the ack
		if (req_write)
		begin
			case (dec)
				DEC_ONE:
					st_next.ctrl[0] = merge16(st_reg.ctrl[0], wb_req.dat, wb_req.sel);
				DEC_TWO:
					st_next.ctrl[1] = merge16(st_reg.ctrl[1], wb_req.dat, wb_req.sel);
				DEC_THRESH:
					st_next.thr = led_pkg::THR_W'(merge16(16'(st_reg.thr), wb_req.dat,
						wb_req.sel));
				default:
					st_next.thr = st_reg.thr;
			endcase
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			st_reg         <= '0;
			st_reg.ctrl[0] <= led_pkg::CTRL_RESET;
			st_reg.ctrl[1] <= led_pkg::CTRL_RESET;
			st_reg.thr     <= led_pkg::THR_RESET;
		end
		else
			st_reg <= st_next;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign indicator_one     = lamp[0];
	assign indicator_two     = lamp[1];
	assign fail_display_busy = st_reg.fail_active;
	assign wb_rsp.ack        = st_reg.ack;
	assign wb_rsp.dat        = st_reg.rdata;

endmodule
`default_nettype wire

// ==== tb/indicator_lamp_model.sv ====
// lamp model: measures on runs, off runs and pulses of one indicator pin
`timescale 1ns/100ps
`default_nettype none
module indicator_lamp_model
(
	input  wire logic ref_clk,
	input  wire logic clr,
	input  wire logic lamp,
	output var int    on_len,
	output var int    off_len,
	output var int    pulses
);
	int   run;
	logic lit;
	always @(posedge ref_clk)
	begin
		if (clr)
		begin
			run     <= 0;
			pulses  <= 0;
			on_len  <= 0;
			off_len <= 0;
			lit     <= lamp;
		end
		else if (lamp !== lit)
		begin
			if (lit)
			begin
				on_len <= run;
				pulses <= pulses + 1;
			end
			else
				off_len <= run;
			run <= 1;
			lit <= lamp;
		end
		else
			run <= run + 1;
	end
endmodule
`default_nettype wire

// ==== tb/status_led_pattern_driver_sva.sv ====
// port-level assertion checker of the status indicator driver
`timescale 1ns/100ps
`default_nettype none
module status_led_pattern_driver_sva
#(
	parameter int TICK_CYCLES = led_pkg::TICK_CYCLES
)
(
	input  wire logic                      ref_clk,
	input  wire logic                      nrst,
	input  wire led_pkg::wb_req_t          wb_req,
	input  wire led_pkg::wb_rsp_t          wb_rsp,
	input  wire led_pkg::pwr_t             pwr_state,
	input  wire logic                      seq_fail,
	input  wire logic [led_pkg::THR_W-1:0] supply_level,
	input  wire logic                      autoprog_done,
	input  wire logic                      autoprog_error,
	input  wire logic                      indicator_one,
	input  wire logic                      indicator_two,
	input  wire logic                      fail_display_busy
);
	// ------------------------------------------------------------
	// helper counters
	// ------------------------------------------------------------
	logic [2:0]  ap1_reg;
	logic [2:0]  ap2_reg;
	logic [2:0]  dark_reg;
	logic [31:0] busy_reg;
	logic        req;
	logic        dark_now;
	assign req = wb_req.cyc && wb_req.stb;
	assign dark_now = !fail_display_busy && !seq_fail && pwr_state != led_pkg::PWR_ACTIVE
		&& pwr_state != led_pkg::PWR_SLEEP;
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			ap1_reg  <= 3'h0;
			ap2_reg  <= 3'h0;
			dark_reg <= 3'h0;
			busy_reg <= 32'h0;
		end
		else
		begin
			ap1_reg  <= (ap1_reg != 3'h0 || autoprog_done) ? ap1_reg + {2'h0, ap1_reg != 3'h7} : 3'h0;
			ap2_reg  <= (ap2_reg != 3'h0 || autoprog_error) ? ap2_reg + {2'h0, ap2_reg != 3'h7} : 3'h0;
			dark_reg <= dark_now ? dark_reg + {2'h0, dark_reg != 3'h7} : 3'h0;
			busy_reg <= fail_display_busy ? busy_reg + 32'h1 : 32'h0;
		end
	end
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	a_ack_pulse: assert property (wb_rsp.ack |=> !wb_rsp.ack)
		else $error("ack held longer than one cycle");
	a_ack_answer: assert property (req && !wb_rsp.ack |=> wb_rsp.ack)
		else $error("request not acknowledged in one cycle");
	a_ack_cause: assert property (!req |=> !wb_rsp.ack)
		else $error("ack without a request");
	a_ctrl_upper_zero: assert property (wb_rsp.ack && !wb_req.we && wb_req.adr == 32'h00010130
		|-> wb_rsp.dat[31:16] == 16'h0) else $error("control read upper half not zero");
	a_done_lamp_one: assert property (ap1_reg == 3'h7 |-> indicator_one)
		else $error("indicator one dark after auto-program success");
	a_err_lamp_two: assert property (ap2_reg == 3'h7 |-> indicator_two)
		else $error("indicator two dark after auto-program error");
	a_off_dark_one: assert property (dark_reg == 3'h7 && ap1_reg == 3'h0 |-> !indicator_one)
		else $error("indicator one lit outside active or sleep");
	a_off_dark_two: assert property (dark_reg == 3'h7 && ap2_reg == 3'h0 |-> !indicator_two)
		else $error("indicator two lit outside active or sleep");
	a_fail_busy: assert property (seq_fail |-> ##[1:2] fail_display_busy)
		else $error("failure display not started");
	a_busy_bound: assert property (busy_reg < 132 * TICK_CYCLES)
		else $error("failure display runs too long");
endmodule
`default_nettype wire

// ==== tb/status_led_pattern_driver_tb.sv ====
// self-checking testbench of the status indicator driver
`timescale 1ns/100ps
`default_nettype none
module status_led_pattern_driver_tb;
	localparam int TC = 8;
	logic                 ref_clk, nrst, seq_fail, autoprog_done, autoprog_error, clr;
	logic                 indicator_one, indicator_two, fail_display_busy;
	logic [11:0]          supply_level;
	led_pkg::wb_req_t     wb_req;
	led_pkg::wb_rsp_t     wb_rsp;
	led_pkg::pwr_t        pwr_state;
	int                   on1, off1, np1, on2, off2, np2, n_errors, n_compared;
	status_led_pattern_driver #(.TICK_CYCLES(TC)) dut_u (.ref_clk(ref_clk), .nrst(nrst),
		.wb_req(wb_req), .wb_rsp(wb_rsp), .pwr_state(pwr_state), .seq_fail(seq_fail),
		.supply_level(supply_level), .autoprog_done(autoprog_done),
		.autoprog_error(autoprog_error), .indicator_one(indicator_one),
		.indicator_two(indicator_two), .fail_display_busy(fail_display_busy));
	indicator_lamp_model m1_u (.ref_clk(ref_clk), .clr(clr), .lamp(indicator_one),
		.on_len(on1), .off_len(off1), .pulses(np1));
	indicator_lamp_model m2_u (.ref_clk(ref_clk), .clr(clr), .lamp(indicator_two),
		.on_len(on2), .off_len(off2), .pulses(np2));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask
	task automatic bus(input logic we, input logic [31:0] adr, wd, output logic [31:0] rd);
		@(posedge ref_clk);
		wb_req <= '{1'b1, 1'b1, we, 4'hf, adr, wd};
		do @(posedge ref_clk); while (wb_rsp.ack !== 1'b1);
		rd = wb_rsp.dat;
		wb_req <= '0;
	endtask
	task automatic wr(input logic [31:0] adr, wd);
		logic [31:0] rd;
		bus(1'b1, adr, wd, rd);
	endtask
	task automatic rdc(input string what, input logic [31:0] adr, exp, mask);
		logic [31:0] rd;
		bus(1'b0, adr, 32'h0, rd);
		chk(what, exp, rd & mask);
	endtask
	task automatic measure(input int n);
		clr <= 1'b1;
		tick(1);
		clr <= 1'b0;
		tick(n);
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic regs_test;
		rdc("ctrl one", 32'h00010130, 32'h0000c026, 32'hffffffff);
		rdc("ctrl two", 32'h00010134, 32'h0000c026, 32'hffffffff);
		rdc("threshold", 32'h00010138, 32'h00000800, 32'hffffffff);
		wr(32'h00010140, 32'h00005a5a);
		rdc("unmapped", 32'h00010140, 32'h0, 32'hffffffff);
	endtask
	task automatic manual_test;
		int on_t[4] = '{16, 4, 2, 1};
		int ra_t[4] = '{1, 2, 3, 7};
		int sq_t[4] = '{1, 2, 4, 7};
		pwr_state <= led_pkg::PWR_ACTIVE;
		wr(32'h00010130, 32'h0000c000);
		tick(4);
		chk("mode off", 32'h0, 32'(indicator_one));
		wr(32'h00010130, 32'h0000c100);
		tick(4);
		chk("mode const", 32'h1, 32'(indicator_one));
		for (int i = 0; i < 4; i++)
		begin
			wr(32'h00010130, 32'h0000c200 | 32'(i << 2) | 32'(i));
			measure(600);
			chk("cont on", 32'(on_t[i] * TC), 32'(on1));
			chk("cont off", 32'(on_t[i] * ra_t[i] * TC), 32'(off1));
		end
		for (int i = 0; i < 4; i++)
		begin
			wr(32'h00010130, 32'h0000c000);
			wr(32'h00010130, 32'h0000c30c | 32'(i << 4));
			measure(200);
			chk("seq pulses", 32'(sq_t[i]), 32'(np1));
			chk("seq ends dark", 32'h0, 32'(indicator_one));
		end
	endtask
	task automatic power_test;
		logic [31:0] rd;
		wr(32'h00010130, 32'h00004000);
		wr(32'h00010134, 32'h00004000);
		pwr_state <= led_pkg::PWR_ACTIVE;
		tick(8);
		chk("active one", 32'h3, 32'({indicator_two, indicator_one}));
		pwr_state <= led_pkg::PWR_SLEEP;
		measure(600);
		chk("sleep on", 32'(4 * TC), 32'(on2));
		chk("sleep off", 32'(28 * TC), 32'(off1));
		supply_level <= 12'h800;
		rdc("low at threshold", 32'h0001013c, 32'h0, 32'h4);
		supply_level <= 12'h7ff;
		pwr_state <= led_pkg::PWR_ACTIVE;
		rdc("low below threshold", 32'h0001013c, 32'h4, 32'h4);
		measure(400);
		chk("low on", 32'(4 * TC), 32'(on1));
		chk("low off", 32'(12 * TC), 32'(off2));
		supply_level <= 12'hfff;
		pwr_state <= led_pkg::PWR_TRANS;
		tick(8);
		chk("trans dark", 32'h0, 32'({indicator_two, indicator_one}));
		pwr_state <= led_pkg::PWR_ACTIVE;
		wr(32'h00010130, 32'h00008000);
		wr(32'h00010134, 32'h00000000);
		tick(8);
		chk("rsvd and off dark", 32'h0, 32'({indicator_two, indicator_one}));
		wr(32'h00010130, 32'h00004000);
		seq_fail <= 1'b1;
		clr <= 1'b1;
		tick(1);
		seq_fail <= 1'b0;
		clr <= 1'b0;
		tick(3);
		chk("fail busy", 32'h1, 32'(fail_display_busy));
		for (rd = 0; rd < 1500 && fail_display_busy !== 1'b0; rd++)
			tick(1);
		chk("fail held", 32'h1, 32'(rd > 890));
		chk("fail pulses", 32'h4, 32'(np1));
		chk("fail on", 32'(16 * TC), 32'(on1));
		chk("fail two dark", 32'h0, 32'(np2));
	endtask
	task automatic autoprog_test;
		wr(32'h00010130, 32'h00000000);
		pwr_state <= led_pkg::PWR_OFF;
		autoprog_done <= 1'b1;
		tick(1);
		autoprog_done <= 1'b0;
		tick(6);
		chk("done lamps", 32'h1, 32'({indicator_two, indicator_one}));
		autoprog_error <= 1'b1;
		tick(1);
		autoprog_error <= 1'b0;
		wr(32'h00010130, 32'h0000c000);
		tick(200);
		chk("latched lamps", 32'h3, 32'({indicator_two, indicator_one}));
		nrst <= 1'b0;
		tick(2);
		nrst <= 1'b1;
		tick(2);
		chk("reset lamps", 32'h0, 32'({indicator_two, indicator_one}));
	endtask
	// ------------------------------------------------------------
	// clock, sequence and watchdog
	// ------------------------------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	initial
	begin
		{nrst, seq_fail, autoprog_done, autoprog_error} = 4'h0;
		wb_req = '0;
		pwr_state = led_pkg::PWR_OFF;
		supply_level = 12'hfff;
		clr = 1'b1;
		n_errors = 0;
		n_compared = 0;
		tick(16);
		nrst <= 1'b1;
		clr <= 1'b0;
		regs_test();
		manual_test();
		power_test();
		autoprog_test();
		report_and_stop();
	end
	initial
	begin
		tick(20000);
		n_errors++;
		$display("watchdog expired");
		report_and_stop();
	end
endmodule
bind status_led_pattern_driver status_led_pattern_driver_sva #(.TICK_CYCLES(TICK_CYCLES)) sva_u
	(.ref_clk(ref_clk), .nrst(nrst), .wb_req(wb_req), .wb_rsp(wb_rsp), .pwr_state(pwr_state),
	.seq_fail(seq_fail), .supply_level(supply_level), .autoprog_done(autoprog_done),
	.autoprog_error(autoprog_error), .indicator_one(indicator_one),
	.indicator_two(indicator_two), .fail_display_busy(fail_display_busy));
`default_nettype wire
